// File: design/cpe_phase_detector.sv
// Capstan phase error detector: preset counter, error latch, register file.
// Assumes a classic Wishbone master on core_clk_i, a same-clock standby
// request and filter mode bit, and asynchronous reference pulse inputs.
//
// Added by the designer: the Wishbone register port.

// Notes on behaviour
// RULE_01 - Preset is byte-preset low nibble on top of word-preset sixteen bits.
// RULE_02 - Writing the word preset loads all twenty bits into the counter preset.
// RULE_03 - Software writes byte preset before word preset.
// RULE_04 - Zero error is count 0x80000; latched count is rebased to zero.
// RULE_05 - Software writes the word preset with word accesses only.
// RULE_06 - Preset registers are write-only; reads return no meaningful data.
// RULE_07 - Reset and standby set byte preset 0xF0, word preset 0x0000.
// RULE_08 - Error register is signed: zero on phase, negative leads, positive lags.
// RULE_09 - Software writes byte error then word error, word accesses only.
// RULE_10 - Reset and standby set byte error 0xF0, word error 0x0000.
// RULE_11 - Clock select 00..11 gives servo clock divided by 1, 2, 4, 8.
// RULE_12 - Counter counts up after preset, stops on overflow or latch, interrupts.
// RULE_13 - Overflow flag clears by writing 0 after reading 1; set wins.
// RULE_14 - Preset source bit: 0 frame reference, 1 alternate capstan reference.
// RULE_15 - Playback pair bit: 0 corrected ref/control; 1 frame ref/tachometer.
// RULE_16 - Transfer mode 0 sends detected error; 1 sends software-written error.
// RULE_17 - Phase interrupt comes from either latch pulse or counter overflow.
// RULE_18 - Control resets to 0x07; three low bits reserved.
// RULE_19 - Playback with pair bit 0 latches on divided control pulse; otherwise on tachometer pulse.
// RULE_20 - Flag writes never restart a stopped counter; only a preset does.
module cpe_phase_detector
  import cpe_pkg::*;
(
  // Clock, reset and power state
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic standby_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cpe_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [cpe_pkg::WB_SEL_W-1:0] wb_sel_i,
  input wire logic [cpe_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [cpe_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Servo mode
  input wire logic playback_mode_i,
  input wire logic error_transfer_mode_i,
  // Reference and latch pulses
  input wire logic internal_frame_reference_i,
  input wire logic alternate_capstan_reference_i,
  input wire logic corrected_capstan_reference_i,
  input wire logic divided_control_pulse_i,
  input wire logic divided_tachometer_pulse_i,
  // Digital filter side
  output logic [cpe_pkg::CNT_W-1:0] filter_error_data_o,
  output logic filter_error_valid_o,
  output logic phase_interrupt_request_o,
  output logic counter_running_o
);

  import cpe_pkg::*;

  // ==========================================================================
  // Helper functions

  // True when the byte address selects the given register index.
  function automatic logic reg_hit(input logic [WB_ADR_W-1:0] adr,
                                   input logic [19:0] idx);
    reg_hit = (adr == {idx, 2'b00});
  endfunction : reg_hit

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = dat[15:8];
    end
  endfunction : merge16

  // ==========================================================================
  // Bus decode
  logic ack_reg;
  logic [WB_DAT_W-1:0] rdata_reg;
  logic access;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_plow;
  logic hit_phigh;
  logic hit_ehigh;
  logic hit_elow;

  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = access & wb_we_i;
  assign rd = access & ~wb_we_i;
  assign hit_ctrl = reg_hit(wb_adr_i, IDX_CONTROL);
  assign hit_plow = reg_hit(wb_adr_i, IDX_PRESET_LOW);
  assign hit_phigh = reg_hit(wb_adr_i, IDX_PRESET_HIGH);
  assign hit_ehigh = reg_hit(wb_adr_i, IDX_ERROR_HIGH);
  assign hit_elow = reg_hit(wb_adr_i, IDX_ERROR_LOW);

  // ==========================================================================
  // Pulse synchronisation and counter clock
  logic [PULSE_N-1:0] pulse_raw;
  logic [PULSE_N-1:0] pulse_rise;
  logic tick;
  logic [1:0] clk_sel_reg;

  assign pulse_raw[PULSE_FRAME] = internal_frame_reference_i;
  assign pulse_raw[PULSE_ALT] = alternate_capstan_reference_i;
  assign pulse_raw[PULSE_CORR] = corrected_capstan_reference_i;
  assign pulse_raw[PULSE_CTL] = divided_control_pulse_i;
  assign pulse_raw[PULSE_TACH] = divided_tachometer_pulse_i;

  cpe_pulse_sync #(
    .WIDTH(PULSE_N)
  ) u_pulse_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(pulse_raw),
    .rise_o(pulse_rise)
  );

  cpe_tick_gen u_tick_gen (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(standby_i),
    .sel_i(clk_sel_reg),
    .tick_o(tick)
  );

  // ==========================================================================
  // Control register
  logic src_sel_reg;
  logic pair_sel_reg;
  logic ovf_flag_reg;
  logic ovf_armed_reg;
  logic ovf_evt;
  logic latch_evt;
  logic ovf_clear;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sel_reg <= RST_CONTROL[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]; // [RULE_18]
      src_sel_reg <= RST_CONTROL[BIT_SRC];
      pair_sel_reg <= RST_CONTROL[BIT_PAIR];
    end else if (ce_i) begin
      if (standby_i) begin
        clk_sel_reg <= RST_CONTROL[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]; // [RULE_18]
        src_sel_reg <= RST_CONTROL[BIT_SRC];
        pair_sel_reg <= RST_CONTROL[BIT_PAIR];
      end else if (wr && hit_ctrl && wb_sel_i[0]) begin
        clk_sel_reg <= wb_dat_i[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]; // [RULE_11]
        src_sel_reg <= wb_dat_i[BIT_SRC]; // [RULE_14]
        pair_sel_reg <= wb_dat_i[BIT_PAIR]; // [RULE_15]
      end
    end
  end

  // A zero write only clears the flag once software has seen it as one.
  assign ovf_clear = wr & hit_ctrl & wb_sel_i[0] & ~wb_dat_i[BIT_OVF] &
                     ovf_armed_reg; // [RULE_13]

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag_reg <= RST_CONTROL[BIT_OVF];
      ovf_armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (standby_i) begin
        ovf_flag_reg <= RST_CONTROL[BIT_OVF];
        ovf_armed_reg <= 1'b0;
      end else if (ovf_evt) begin
        ovf_flag_reg <= 1'b1; // [RULE_12] [RULE_13]
        ovf_armed_reg <= 1'b0;
      end else if (ovf_clear) begin
        ovf_flag_reg <= 1'b0; // [RULE_13]
        ovf_armed_reg <= 1'b0;
      end else if (rd && hit_ctrl && ovf_flag_reg) begin
        ovf_armed_reg <= 1'b1; // [RULE_13]
      end
    end
  end

  // ==========================================================================
  // Preset registers
  logic [3:0] preset_high_reg;
  logic [15:0] preset_low_reg;
  logic [CNT_W-1:0] preset_value_reg;
  logic [15:0] preset_low_next;

  assign preset_low_next = merge16(preset_low_reg, wb_dat_i, wb_sel_i);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      preset_high_reg <= RST_PRESET_HIGH[3:0]; // [RULE_07]
      preset_low_reg <= RST_PRESET_LOW; // [RULE_07]
      preset_value_reg <= {RST_PRESET_HIGH[3:0], RST_PRESET_LOW};
    end else if (ce_i) begin
      if (standby_i) begin
        preset_high_reg <= RST_PRESET_HIGH[3:0]; // [RULE_07]
        preset_low_reg <= RST_PRESET_LOW; // [RULE_07]
        preset_value_reg <= {RST_PRESET_HIGH[3:0], RST_PRESET_LOW};
      end else if (wr && hit_phigh && wb_sel_i[0]) begin
        preset_high_reg <= wb_dat_i[3:0]; // [RULE_01]
      end else if (wr && hit_plow) begin
        preset_low_reg <= preset_low_next;
        preset_value_reg <= {preset_high_reg, preset_low_next}; // [RULE_01] [RULE_02]
      end
    end
  end

  // ==========================================================================
  // Preset and latch pulse selection
  logic frame_pulse;
  logic preset_pulse;
  logic latch_pulse;
  logic use_control_pair;

  assign frame_pulse = src_sel_reg ? pulse_rise[PULSE_ALT]
                                   : pulse_rise[PULSE_FRAME]; // [RULE_14]
  assign use_control_pair = playback_mode_i & ~pair_sel_reg; // [RULE_15]
  assign preset_pulse = use_control_pair ? pulse_rise[PULSE_CORR]
                                         : frame_pulse; // [RULE_15]
  assign latch_pulse = use_control_pair ? pulse_rise[PULSE_CTL]
                                        : pulse_rise[PULSE_TACH]; // [RULE_19]

  // ==========================================================================
  // Phase error counter
  cpe_state_e state_reg;
  logic [CNT_W-1:0] count_reg;
  logic running;

  assign running = (state_reg == ST_RUN);
  assign latch_evt = ce_i & ~standby_i & running & latch_pulse; // [RULE_17]
  assign ovf_evt = ce_i & ~standby_i & running & ~latch_pulse & tick &
                   (count_reg == COUNT_MAX); // [RULE_12] [RULE_17]

  // A latch and a preset in the same cycle both act: the finished measurement
  // is kept and the next one starts.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else if (ce_i) begin
      if (standby_i) begin
        state_reg <= ST_IDLE;
        count_reg <= '0;
      end else begin
        case (state_reg)
          ST_IDLE, ST_HALT: begin
            if (preset_pulse) begin
              state_reg <= ST_RUN; // [RULE_20]
              count_reg <= preset_value_reg;
            end
          end
          ST_RUN: begin
            if (preset_pulse) begin
              count_reg <= preset_value_reg;
            end else if (latch_evt || ovf_evt) begin
              state_reg <= ST_HALT; // [RULE_12]
            end else if (tick) begin
              count_reg <= count_reg + 1'b1; // [RULE_12]
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Error registers
  logic [CNT_W-1:0] error_reg;
  logic [CNT_W-1:0] detected_error;
  logic sw_error_send;

  // Flipping the top bit subtracts the zero-error reference modulo 2^20.
  assign detected_error = count_reg ^ ZERO_ERROR_REF; // [RULE_04] [RULE_08]
  assign sw_error_send = wr & hit_elow & error_transfer_mode_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      error_reg <= {RST_ERROR_HIGH[3:0], RST_ERROR_LOW}; // [RULE_10]
    end else if (ce_i) begin
      if (standby_i) begin
        error_reg <= {RST_ERROR_HIGH[3:0], RST_ERROR_LOW}; // [RULE_10]
      end else if (latch_evt) begin
        error_reg <= detected_error; // [RULE_04]
      end else if (wr && hit_ehigh && wb_sel_i[0]) begin
        error_reg[19:16] <= wb_dat_i[3:0];
      end else if (wr && hit_elow) begin
        error_reg[15:0] <= merge16(error_reg[15:0], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ==========================================================================
  // Filter transfer and interrupt
  logic [CNT_W-1:0] filter_data_reg;
  logic filter_valid_reg;
  logic irq_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filter_data_reg <= '0;
      filter_valid_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      filter_valid_reg <= 1'b0;
      irq_reg <= latch_evt | ovf_evt; // [RULE_12] [RULE_17]
      if (standby_i) begin
        filter_data_reg <= '0;
      end else if (latch_evt && !error_transfer_mode_i) begin
        filter_data_reg <= detected_error; // [RULE_16]
        filter_valid_reg <= 1'b1;
      end else if (sw_error_send && !latch_evt) begin
        filter_data_reg <= {error_reg[19:16],
                            merge16(error_reg[15:0], wb_dat_i,
                                    wb_sel_i)}; // [RULE_16]
        filter_valid_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Bus answer
  logic [WB_DAT_W-1:0] rdata_mux;

  always_comb begin
    rdata_mux = '0;
    if (hit_ctrl) begin
      rdata_mux[7:0] = {clk_sel_reg, ovf_flag_reg, src_sel_reg,
                        pair_sel_reg, CTRL_RESERVED_BITS};
    end else if (hit_ehigh) begin
      rdata_mux[7:0] = {HIGH_UNUSED_BITS, error_reg[19:16]};
    end else if (hit_elow) begin
      rdata_mux[15:0] = error_reg[15:0];
    end
    // Preset registers are write-only and read as zero. [RULE_06]
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (ce_i) begin
      ack_reg <= access;
      if (rd) begin
        rdata_reg <= rdata_mux;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign filter_error_data_o = filter_data_reg;
  assign filter_error_valid_o = filter_valid_reg;
  assign phase_interrupt_request_o = irq_reg;
  assign counter_running_o = running;

endmodule : cpe_phase_detector

// File: shared/cpe_pkg.sv
// Constants shared by the capstan phase error detector and its helpers.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package cpe_pkg;

  // ==========================================================================
  // Bus and datapath widths
  localparam int WB_ADR_W = 22;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int CNT_W = 20;
  localparam int PRESCALE_W = 3;
  localparam int PULSE_N = 5;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [19:0] IDX_CONTROL = 20'hF_D059;
  localparam logic [19:0] IDX_PRESET_LOW = 20'hF_D05A;
  localparam logic [19:0] IDX_PRESET_HIGH = 20'hF_D05C;
  localparam logic [19:0] IDX_ERROR_HIGH = 20'hF_D05D;
  localparam logic [19:0] IDX_ERROR_LOW = 20'hF_D05E;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h07;
  localparam logic [7:0] RST_PRESET_HIGH = 8'hF0;
  localparam logic [15:0] RST_PRESET_LOW = 16'h0000;
  localparam logic [7:0] RST_ERROR_HIGH = 8'hF0;
  localparam logic [15:0] RST_ERROR_LOW = 16'h0000;
  localparam logic [3:0] HIGH_UNUSED_BITS = 4'hF;
  localparam logic [2:0] CTRL_RESERVED_BITS = 3'h7;

  // ==========================================================================
  // Control field positions
  localparam int BIT_CLK_SEL_HI = 7;
  localparam int BIT_CLK_SEL_LO = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_SRC = 4;
  localparam int BIT_PAIR = 3;

  // ==========================================================================
  // Counter references
  localparam logic [19:0] ZERO_ERROR_REF = 20'h8_0000;
  localparam logic [19:0] COUNT_MAX = 20'hF_FFFF;

  // ==========================================================================
  // Pulse vector positions
  localparam int PULSE_FRAME = 0;
  localparam int PULSE_ALT = 1;
  localparam int PULSE_CORR = 2;
  localparam int PULSE_CTL = 3;
  localparam int PULSE_TACH = 4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CLK_DIV1 = 2'b00,
    CLK_DIV2 = 2'b01,
    CLK_DIV4 = 2'b10,
    CLK_DIV8 = 2'b11
  } cpe_clk_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b11
  } cpe_state_e;

endpackage : cpe_pkg

// File: design/cpe_pulse_sync.sv
// Synchroniser and rising-edge detector for the reference pulse inputs.
// Assumes the inputs are asynchronous to core_clk_i and wider than a period.
module cpe_pulse_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pulses
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] rise_o
);

  // ==========================================================================
  // Two-flop synchroniser followed by a history flop
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] hist_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      hist_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~hist_reg;

endmodule : cpe_pulse_sync

// File: design/cpe_tick_gen.sv
// Counter clock generator: divides the servo clock by 1, 2, 4 or 8.
// Assumes core_clk_i is the servo clock; ticks are one-cycle enables.
module cpe_tick_gen
  import cpe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  // Selection and tick
  input wire logic [1:0] sel_i,
  output logic tick_o
);

  // ==========================================================================
  // Free-running prescaler
  logic [PRESCALE_W-1:0] pre_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        pre_reg <= '0;
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

  always_comb begin
    case (cpe_clk_sel_e'(sel_i))
      CLK_DIV1: tick_o = ce_i; // [RULE_11]
      CLK_DIV2: tick_o = ce_i & (pre_reg[0] == 1'b1); // [RULE_11]
      CLK_DIV4: tick_o = ce_i & (pre_reg[1:0] == 2'b11); // [RULE_11]
      CLK_DIV8: tick_o = ce_i & (pre_reg == 3'b111); // [RULE_11]
      default: tick_o = 1'b0;
    endcase
  end

endmodule : cpe_tick_gen

// File: testbench/cpe_phase_chk.sv
// Checker for bus, interrupt and filter timing.
// Assumes ce_i is held high by the surroundings.
module cpe_phase_chk
  import cpe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cpe_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [cpe_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Servo side
  input wire logic error_transfer_mode_i,
  input wire logic internal_frame_reference_i,
  input wire logic alternate_capstan_reference_i,
  input wire logic corrected_capstan_reference_i,
  input wire logic filter_error_valid_o,
  input wire logic phase_interrupt_request_o,
  input wire logic counter_running_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic pre_any;
  logic rd_ack;
  assign pre_any = internal_frame_reference_i | alternate_capstan_reference_i
    | corrected_capstan_reference_i;
  assign rd_ack = wb_ack_o & ~wb_we_i;
  // ==========
  // Properties
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_preset_wo;
    rd_ack && (wb_adr_i == {IDX_PRESET_LOW, 2'b00} ||
      wb_adr_i == {IDX_PRESET_HIGH, 2'b00}) |-> wb_dat_o == '0;
  endproperty
  a_preset_wo: assert property (p_preset_wo) else $error("preset read");
  property p_ctrl_rsvd;
    rd_ack && wb_adr_i == {IDX_CONTROL, 2'b00} |-> wb_dat_o[2:0] == 3'h7;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("ctrl low");
  property p_irq_on_halt;
    $fell(counter_running_o) && !$past(standby_i) |->
      phase_interrupt_request_o;
  endproperty
  a_irq_on_halt: assert property (p_irq_on_halt) else $error("no irq");
  property p_irq_cause;
    $rose(phase_interrupt_request_o) |-> $past(counter_running_o);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
  property p_auto_send;
    filter_error_valid_o && !error_transfer_mode_i |->
      phase_interrupt_request_o;
  endproperty
  a_auto_send: assert property (p_auto_send) else $error("auto send");
  property p_sw_send;
    wb_ack_o && wb_we_i && wb_adr_i == {IDX_ERROR_LOW, 2'b00} &&
      error_transfer_mode_i |-> ##[0:1] filter_error_valid_o;
  endproperty
  a_sw_send: assert property (p_sw_send) else $error("sw send");
  property p_run_by_preset;
    $rose(counter_running_o) |-> $past(pre_any, 3);
  endproperty
  a_run_by_preset: assert property (p_run_by_preset) else $error("start");
endmodule : cpe_phase_chk

bind cpe_phase_detector cpe_phase_chk u_chk (
  .core_clk_i, .rst_i, .standby_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .error_transfer_mode_i,
  .internal_frame_reference_i, .alternate_capstan_reference_i,
  .corrected_capstan_reference_i, .filter_error_valid_o,
  .phase_interrupt_request_o, .counter_running_o
);

// File: testbench/cpe_servo_model.sv
// Far side model: reference pulse generators and the filter input.
// Assumes pulses are launched just after a rising edge of core_clk_i.
module cpe_servo_model
  import cpe_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Pulses to the detector
  output logic [cpe_pkg::PULSE_N-1:0] pulse_o,
  // Filter input
  input wire logic [cpe_pkg::CNT_W-1:0] filter_error_data_i,
  input wire logic filter_error_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CNT_W-1:0] last_data;
  int sends;
  initial begin
    pulse_o = '0;
    last_data = '0;
    sends = 0;
  end
  // The filter keeps the last word and counts sends.
  always @(posedge core_clk_i) begin
    if (filter_error_valid_i === 1'b1) begin
      last_data <= filter_error_data_i;
      sends <= sends + 1;
    end
  end
  // Four cycles high outlasts the synchroniser.
  task automatic fire(input int idx);
    pulse_o[idx] <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    pulse_o[idx] <= 1'b0;
  endtask : fire
endmodule : cpe_servo_model

// File: testbench/tb_top.sv
// Self-checking bench for the capstan phase error detector.
// Assumes the servo model drives the pulses and the checker is bound.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpe_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic standby_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr_i = '0;
  logic [WB_SEL_W-1:0] wb_sel_i = '0;
  logic [WB_DAT_W-1:0] wb_dat_i = '0;
  logic [WB_DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic playback_mode_i = 1'b0;
  logic error_transfer_mode_i = 1'b0;
  logic [PULSE_N-1:0] pulse;
  logic [CNT_W-1:0] filter_error_data_o;
  logic filter_error_valid_o;
  logic phase_interrupt_request_o;
  logic counter_running_o;
  logic [31:0] rq;
  logic [19:0] err;
  logic [7:0] m;
  int sends;
  int bad_count = 0;
  int check_count = 0;
  logic [19:0] ridx [6] = '{IDX_CONTROL, IDX_ERROR_HIGH, IDX_ERROR_LOW,
    IDX_PRESET_HIGH, IDX_PRESET_LOW, 20'hF_D05F};
  logic [31:0] rexp [6] = '{32'h0000_0007, 32'h0000_00F0, '0, '0, '0, '0};
  logic pbk [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [1:0] mcfg [4] = '{2'b00, 2'b10, 2'b00, 2'b11};
  int pre [4] = '{PULSE_FRAME, PULSE_ALT, PULSE_CORR, PULSE_ALT};
  int bpre [4] = '{PULSE_ALT, PULSE_FRAME, PULSE_FRAME, PULSE_CORR};
  int lat [4] = '{PULSE_TACH, PULSE_TACH, PULSE_CTL, PULSE_TACH};
  int blat [4] = '{PULSE_CTL, PULSE_CTL, PULSE_TACH, PULSE_CTL};

  always #20 core_clk_i = ~core_clk_i;

  cpe_phase_detector DUT (
    .core_clk_i, .rst_i, .ce_i(1'b1), .standby_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .playback_mode_i, .error_transfer_mode_i,
    .internal_frame_reference_i(pulse[PULSE_FRAME]),
    .alternate_capstan_reference_i(pulse[PULSE_ALT]),
    .corrected_capstan_reference_i(pulse[PULSE_CORR]),
    .divided_control_pulse_i(pulse[PULSE_CTL]),
    .divided_tachometer_pulse_i(pulse[PULSE_TACH]),
    .filter_error_data_o, .filter_error_valid_o,
    .phase_interrupt_request_o, .counter_running_o
  );
  cpe_servo_model srv (
    .core_clk_i, .pulse_o(pulse),
    .filter_error_data_i(filter_error_data_o),
    .filter_error_valid_i(filter_error_valid_o)
  );

  // ==========
  // Tasks
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cycles
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Allow two ticks of prescaler phase.
  task automatic near(input string name, input logic [19:0] seen,
      input logic [19:0] exp);
    logic [19:0] d;
    d = seen - exp + 20'h0_0002;
    check(name, (d <= 20'h0_0004) ? exp : seen, exp);
  endtask : near
  task automatic bus(input logic w, input logic [19:0] idx,
      input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= (idx == IDX_PRESET_LOW || idx == IDX_ERROR_LOW) ? 4'h3 : 4'h1;
    wb_dat_i <= d;
    do cycles(1);
    while (wb_ack_o !== 1'b1);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    cycles(1);
    check("ack", {31'h0, wb_ack_o}, '0);
  endtask : bus
  task automatic wrrd(input logic [7:0] d, input logic [31:0] e);
    bus(1'b1, IDX_CONTROL, {24'h0, d});
    bus(1'b0, IDX_CONTROL, '0);
    check("control", rq, e);
  endtask : wrrd
  task automatic init_reads();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ridx[i], '0);
      check("init", rq, rexp[i]);
    end
  endtask : init_reads
  task automatic run_pair(input int p, input int l);
    sends = srv.sends;
    srv.fire(p);
    cycles(36);
    srv.fire(l);
    cycles(10);
    bus(1'b0, IDX_ERROR_HIGH, '0);
    err[19:16] = rq[3:0];
    bus(1'b0, IDX_ERROR_LOW, '0);
    err[15:0] = rq[15:0];
  endtask : run_pair
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ==========
  // Sequence
  initial begin
    cycles(8);
    rst_i <= 1'b0;
    cycles(1);
    init_reads();
    // Each mode also sees a wrong latch and a wrong preset mid-count.
    for (int i = 0; i < 4; i++) begin
      playback_mode_i <= pbk[i];
      m = {i[1:0], 1'b0, mcfg[i], 3'h0};
      wrrd(m, {24'h0, m | 8'h07});
      bus(1'b1, IDX_PRESET_HIGH, 32'h0000_0008);
      bus(1'b1, IDX_PRESET_LOW, 32'h0000_0000);
      srv.fire(pre[i]);
      cycles(36);
      srv.fire(blat[i]);
      cycles(36);
      run_pair(bpre[i], lat[i]);
      near("error", err, 20'(120 >> i));
      check("filter", {12'h0, srv.last_data}, {12'h0, err});
      check("sends", srv.sends - sends, 32'h0000_0001);
      check("run", {31'h0, counter_running_o}, '0);
    end
    playback_mode_i <= 1'b0;
    wrrd(8'h00, 32'h0000_0007);
    bus(1'b1, IDX_PRESET_HIGH, 32'h0000_0007);
    bus(1'b1, IDX_PRESET_LOW, 32'h0000_FFB0);
    run_pair(PULSE_FRAME, PULSE_TACH);
    near("lead", err, 20'hF_FFD8);
    bus(1'b1, IDX_PRESET_HIGH, 32'h0000_000F);
    bus(1'b1, IDX_PRESET_LOW, 32'h0000_FFF0);
    srv.fire(PULSE_FRAME);
    cycles(40);
    bus(1'b0, IDX_CONTROL, '0);
    check("overflow", rq, 32'h0000_0027);
    wrrd(8'h00, 32'h0000_0007);
    wrrd(8'h20, 32'h0000_0007);
    check("stopped", {31'h0, counter_running_o}, '0);
    error_transfer_mode_i <= 1'b1;
    sends = srv.sends;
    bus(1'b1, IDX_ERROR_HIGH, 32'h0000_000A);
    bus(1'b1, IDX_ERROR_LOW, 32'h0000_1234);
    cycles(3);
    check("sw word", {12'h0, srv.last_data}, 32'h000A_1234);
    check("sw sends", srv.sends - sends, 32'h0000_0001);
    error_transfer_mode_i <= 1'b0;
    standby_i <= 1'b1;
    cycles(2);
    standby_i <= 1'b0;
    cycles(1);
    init_reads();
    bus(1'b1, IDX_PRESET_LOW, 32'h0000_0000);
    run_pair(PULSE_FRAME, PULSE_TACH);
    near("preset init", err, 20'h8_0028);
    conclude();
  end

  initial begin
    cycles(20000);
    check("watchdog", 32'h0000_0000, 32'h0000_0001);
    conclude();
  end
endmodule : tb_top
